// ==== common/seg_trig_pkg.sv ====
// Purpose: shared constants and types for the level/window trigger and segment recorder
// Assumes: 32-bit APB data, register byte address = index * 4
// Notes:   indexes are kept as printed; byte addresses derive from them
package seg_trig_pkg;
  localparam int ADDR_W   = 18;
  localparam int SAMPLE_W = 14;
  localparam int DATA_W   = 32;

  localparam logic [15:0] IDX_TOTAL_LEN  = 16'h2710;
  localparam logic [15:0] IDX_SEG_LEN    = 16'h271a;
  localparam logic [15:0] IDX_POST_CNT   = 16'h2774;
  localparam logic [15:0] IDX_CTRL       = 16'h27d8;
  localparam logic [15:0] IDX_STATUS     = 16'h27e2;
  localparam logic [15:0] IDX_TRIG_POS   = 16'h27ec;
  localparam logic [15:0] IDX_IRQ_STAT   = 16'h283c;
  localparam logic [15:0] IDX_IRQ_EN     = 16'h2846;
  localparam logic [15:0] IDX_IRQ_CLR    = 16'h2850;
  localparam logic [15:0] IDX_TRIG_MODE  = 16'h9ea2;
  localparam logic [15:0] IDX_LEVEL_PRI  = 16'ha4d8;
  localparam logic [15:0] IDX_LEVEL_SEC  = 16'ha53c;

  localparam logic [DATA_W-1:0] BELOW_LEVEL_CONDITION  = 32'h0000_0010;
  localparam logic [DATA_W-1:0] INSIDE_BAND_CONDITION  = 32'h0000_0080;
  localparam logic [DATA_W-1:0] OUTSIDE_BAND_CONDITION = 32'h0000_0100;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT  = 1;
  localparam int IRQ_W          = 3;
  localparam int IRQ_SEG_BIT    = 0;
  localparam int IRQ_DONE_BIT   = 1;
  localparam int IRQ_ERR_BIT    = 2;

  localparam logic [DATA_W-1:0] PRE_EVENT_MAX   = 32'h0000_2000;
  localparam logic [DATA_W-1:0] ZERO_WORD       = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ONE_WORD        = 32'h0000_0001;

  localparam logic [ADDR_W-1:0] ADDR_TOTAL_LEN = ADDR_W'({IDX_TOTAL_LEN, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_SEG_LEN   = ADDR_W'({IDX_SEG_LEN, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_POST_CNT  = ADDR_W'({IDX_POST_CNT, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_CTRL      = ADDR_W'({IDX_CTRL, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = ADDR_W'({IDX_STATUS, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_TRIG_POS  = ADDR_W'({IDX_TRIG_POS, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT  = ADDR_W'({IDX_IRQ_STAT, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN    = ADDR_W'({IDX_IRQ_EN, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR   = ADDR_W'({IDX_IRQ_CLR, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_TRIG_MODE = ADDR_W'({IDX_TRIG_MODE, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_LEVEL_PRI = ADDR_W'({IDX_LEVEL_PRI, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_LEVEL_SEC = ADDR_W'({IDX_LEVEL_SEC, 2'b00});

  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_PRE   = 6'b000010,
    S_ARMED = 6'b000100,
    S_POST  = 6'b001000,
    S_REARM = 6'b010000,
    S_DONE  = 6'b100000
  } rec_state_type;

  typedef struct packed {
    logic [DATA_W-1:0]          mode;
    logic signed [SAMPLE_W-1:0] upper;
    logic signed [SAMPLE_W-1:0] lower;
  } trig_cfg_type;

  typedef struct packed {
    logic                we;
    logic [DATA_W-1:0]   addr;
    logic [SAMPLE_W-1:0] data;
  } mem_wr_type;
endpackage

// ==== verilog/level_trig_detect.sv ====
// Purpose: compares each sample with the levels, gives gate level and event pulse
// Assumes: samples are two's complement, same clock as the recorder
// Notes:   event is the first sample of a true condition seen while armed
`timescale 1ns/10ps
module level_trig_detect
  import seg_trig_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire trig_cfg_type               cfg_i,
  input  wire logic                       restart_i,
  input  wire logic                       arm_i,
  input  wire logic                       valid_i,
  input  wire logic signed [SAMPLE_W-1:0] sample_i,
  output logic                            gate_o,
  output logic                            trig_o
);
  logic cond;
  logic prev_reg;
  logic tracking_reg;

  always_comb
  begin
    case (cfg_i.mode)
      BELOW_LEVEL_CONDITION:  cond = sample_i < cfg_i.upper;
      INSIDE_BAND_CONDITION:  cond = (sample_i >= cfg_i.lower) && (sample_i <= cfg_i.upper);
      OUTSIDE_BAND_CONDITION: cond = (sample_i < cfg_i.lower) || (sample_i > cfg_i.upper);
      default:                cond = 1'b0;
    endcase
  end

  // history held clear until the first armed sample; otherwise the pre fill
  // would swallow a condition already true at start
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prev_reg     <= 1'b0;
      tracking_reg <= 1'b0;
    end
    else if (restart_i)
    begin
      prev_reg     <= 1'b0;
      tracking_reg <= 1'b0;
    end
    else if (valid_i && (arm_i || tracking_reg))
    begin
      prev_reg     <= cond;
      tracking_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gate_o <= 1'b0;
      trig_o <= 1'b0;
    end
    else
    begin
      if (valid_i)
        gate_o <= cond;
      trig_o <= valid_i && arm_i && !restart_i && cond && !prev_reg;
    end
  end
endmodule

// ==== verilog/seg_trig_record.sv ====
// Purpose: level/window trigger with hardware segmented recording, APB registers
// Assumes: converter samples arrive on mclk_i; memory takes one write per cycle
// Notes:   zero-wait-free APB slave, answers one cycle into the access phase
// Contract
// - low code flags samples below primary level
// - low mode fires on entering region; the code also fires at start if the first armed sample is already below
// - each mode drives an internal gate level
// - in-window code flags samples between levels
// - in-window fires on entry, or at start
// - outside code flags samples beyond band
// - outside fires on leaving, or at start
// - comparison runs on every sample
// - memory split into equal-size segments
// - each trigger fills the next segment
// - segments follow without software restart
// - hardware re-arms shortly after segment end
// - post count sets samples after trigger
// - segment length includes pre-trigger samples
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
module seg_trig_record
  import seg_trig_pkg::*;
#(
  parameter logic [DATA_W-1:0] PRE_MAX = PRE_EVENT_MAX
)
(
  input  wire logic                mclk_i,
  input  wire logic                rst_b_i,
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [ADDR_W-1:0]   paddr_i,
  input  wire logic [DATA_W-1:0]   pwdata_i,
  input  wire logic                sample_valid_i,
  input  wire logic [SAMPLE_W-1:0] sample_i,
  output logic                     pready_o,
  output logic [DATA_W-1:0]        prdata_o,
  output logic                     pslverr_o,
  output mem_wr_type               mem_o,
  output logic                     gate_o,
  output logic                     irq_o
);
  logic                rst_meta_reg;
  logic                rst_n;
  logic [DATA_W-1:0]   seg_len_reg;
  logic [DATA_W-1:0]   post_reg;
  logic [DATA_W-1:0]   total_reg;
  logic [DATA_W-1:0]   mode_reg;
  logic [DATA_W-1:0]   lvl_pri_reg;
  logic [DATA_W-1:0]   lvl_sec_reg;
  logic [IRQ_W-1:0]    irq_stat_reg;
  logic [IRQ_W-1:0]    irq_en_reg;
  logic [IRQ_W-1:0]    irq_set;
  logic [IRQ_W-1:0]    irq_clr;
  logic [DATA_W-1:0]   trig_pos_reg;
  logic [DATA_W-1:0]   seg_cnt_reg;
  logic [DATA_W-1:0]   base_reg;
  logic [DATA_W-1:0]   ofs_reg;
  logic [DATA_W-1:0]   fill_reg;
  logic [DATA_W-1:0]   post_left_reg;
  logic                valid_d_reg;
  logic [SAMPLE_W-1:0] sample_d_reg;
  logic                cfg_err_reg;
  rec_state_type       state_reg;
  rec_state_type       state_next;
  logic                acc;
  logic                wr_acc;
  logic                mapped;
  logic [DATA_W-1:0]   rd_data;
  logic [DATA_W-1:0]   pre_len;
  logic                cfg_err;
  logic                start_req;
  logic                stop_req;
  logic                trig_pulse;
  logic                restart;
  logic [DATA_W-1:0]   ofs_inc;
  logic [DATA_W-1:0]   next_base;
  trig_cfg_type        trig_cfg;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // apb: pready rises one cycle into the access phase
  assign acc    = psel_i && penable_i && pready_o;
  assign wr_acc = acc && pwrite_i;

  always_comb
  begin
    mapped  = 1'b1;
    rd_data = ZERO_WORD;
    case (paddr_i)
      ADDR_TOTAL_LEN: rd_data = total_reg;
      ADDR_SEG_LEN:   rd_data = seg_len_reg;
      ADDR_POST_CNT:  rd_data = post_reg;
      ADDR_CTRL:      rd_data = ZERO_WORD;
      ADDR_STATUS:    rd_data = {seg_cnt_reg[DATA_W-8:0], cfg_err_reg, 6'(state_reg)};
      ADDR_TRIG_POS:  rd_data = trig_pos_reg;
      ADDR_IRQ_STAT:  rd_data = DATA_W'(irq_stat_reg);
      ADDR_IRQ_EN:    rd_data = DATA_W'(irq_en_reg);
      ADDR_IRQ_CLR:   rd_data = ZERO_WORD;
      ADDR_TRIG_MODE: rd_data = mode_reg;
      ADDR_LEVEL_PRI: rd_data = lvl_pri_reg;
      ADDR_LEVEL_SEC: rd_data = lvl_sec_reg;
      default:        mapped  = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_o  <= 1'b0;
      prdata_o  <= ZERO_WORD;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= psel_i && penable_i && !pready_o;
      prdata_o  <= (psel_i && penable_i && !pready_o && !pwrite_i) ? rd_data : ZERO_WORD;
      pslverr_o <= psel_i && penable_i && !pready_o && !mapped;
    end
  end

  // configuration registers; window bounds come from software as upper/lower
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seg_len_reg <= ZERO_WORD;
      post_reg    <= ZERO_WORD;
      total_reg   <= ZERO_WORD;
      mode_reg    <= ZERO_WORD;
      lvl_pri_reg <= ZERO_WORD;
      lvl_sec_reg <= ZERO_WORD;
      irq_en_reg  <= '0;
    end
    else if (wr_acc)
    begin
      case (paddr_i)
        ADDR_SEG_LEN:   seg_len_reg <= pwdata_i;
        ADDR_POST_CNT:  post_reg    <= pwdata_i;
        ADDR_TOTAL_LEN: total_reg   <= pwdata_i;
        ADDR_TRIG_MODE: mode_reg    <= pwdata_i;
        ADDR_LEVEL_PRI: lvl_pri_reg <= pwdata_i;
        ADDR_LEVEL_SEC: lvl_sec_reg <= pwdata_i;
        ADDR_IRQ_EN:    irq_en_reg  <= pwdata_i[IRQ_W-1:0];
        default:        ;
      endcase
    end
  end

  assign start_req = wr_acc && (paddr_i == ADDR_CTRL) && pwdata_i[CTRL_START_BIT];
  assign stop_req  = wr_acc && (paddr_i == ADDR_CTRL) && pwdata_i[CTRL_STOP_BIT];
  assign irq_clr   = (wr_acc && (paddr_i == ADDR_IRQ_CLR)) ? pwdata_i[IRQ_W-1:0] : '0;

  // pre length derived, checked before a start is accepted
  assign pre_len = seg_len_reg - post_reg;
  assign cfg_err = (post_reg == ZERO_WORD) || (post_reg > seg_len_reg) ||
                   (pre_len > PRE_MAX) || (seg_len_reg > total_reg);

  assign trig_cfg.mode  = mode_reg;
  assign trig_cfg.upper = lvl_pri_reg[SAMPLE_W-1:0];
  assign trig_cfg.lower = lvl_sec_reg[SAMPLE_W-1:0];
  assign restart        = start_req && !cfg_err;

  level_trig_detect u_detect (
    .clk_i     (mclk_i),
    .rst_n_i   (rst_n),
    .cfg_i     (trig_cfg),
    .restart_i (restart),
    .arm_i     (state_reg == S_ARMED),
    .valid_i   (sample_valid_i),
    .sample_i  (sample_i),
    .gate_o    (gate_o),
    .trig_o    (trig_pulse)
  );

  // sample delayed one cycle so it lines up with the trigger pulse
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valid_d_reg  <= 1'b0;
      sample_d_reg <= '0;
    end
    else
    begin
      valid_d_reg  <= sample_valid_i;
      sample_d_reg <= sample_i;
    end
  end

  assign ofs_inc   = (ofs_reg + ONE_WORD >= seg_len_reg) ? ZERO_WORD : ofs_reg + ONE_WORD;
  assign next_base = base_reg + seg_len_reg;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE, S_DONE:
        if (restart)
          state_next = (pre_len == ZERO_WORD) ? S_ARMED : S_PRE;
      S_PRE:
        if (valid_d_reg && (fill_reg + ONE_WORD >= pre_len))
          state_next = S_ARMED;
      S_ARMED:
        if (valid_d_reg && trig_pulse)
          state_next = (post_reg == ONE_WORD) ? S_REARM : S_POST;
      S_POST:
        if (valid_d_reg && (post_left_reg == ONE_WORD))
          state_next = S_REARM;
      S_REARM:
        if (next_base + seg_len_reg > total_reg)
          state_next = S_DONE;
        else
          state_next = (pre_len == ZERO_WORD) ? S_ARMED : S_PRE;
      default:
        state_next = S_IDLE;
    endcase
    if (stop_req)
      state_next = S_IDLE;
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= S_IDLE;
    else
      state_reg <= state_next;
  end

  // segment bookkeeping; pre samples wrap inside the segment as a ring
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base_reg      <= ZERO_WORD;
      ofs_reg       <= ZERO_WORD;
      fill_reg      <= ZERO_WORD;
      post_left_reg <= ZERO_WORD;
      seg_cnt_reg   <= ZERO_WORD;
      trig_pos_reg  <= ZERO_WORD;
    end
    else if (restart && (state_reg == S_IDLE || state_reg == S_DONE))
    begin
      base_reg    <= ZERO_WORD;
      ofs_reg     <= ZERO_WORD;
      fill_reg    <= ZERO_WORD;
      seg_cnt_reg <= ZERO_WORD;
    end
    else
    begin
      case (state_reg)
        S_PRE, S_ARMED, S_POST:
          if (valid_d_reg)
          begin
            ofs_reg  <= ofs_inc;
            fill_reg <= fill_reg + ONE_WORD;
          end
        S_REARM:
        begin
          base_reg    <= next_base;
          ofs_reg     <= ZERO_WORD;
          fill_reg    <= ZERO_WORD;
          seg_cnt_reg <= seg_cnt_reg + ONE_WORD;
        end
        default: ;
      endcase
      if (state_reg == S_ARMED && valid_d_reg && trig_pulse)
      begin
        trig_pos_reg  <= ofs_reg;
        post_left_reg <= post_reg - ONE_WORD;
      end
      else if (state_reg == S_POST && valid_d_reg)
        post_left_reg <= post_left_reg - ONE_WORD;
    end
  end

  // memory write port, registered
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      mem_o <= '0;
    else
    begin
      mem_o.we   <= valid_d_reg &&
                    (state_reg == S_PRE || state_reg == S_ARMED || state_reg == S_POST);
      mem_o.addr <= base_reg + ofs_reg;
      mem_o.data <= sample_d_reg;
    end
  end

  // sticky events; a set in the clearing cycle wins
  always_comb
  begin
    irq_set               = '0;
    irq_set[IRQ_SEG_BIT]  = (state_reg == S_REARM);
    irq_set[IRQ_DONE_BIT] = (state_reg == S_REARM) && (state_next == S_DONE);
    irq_set[IRQ_ERR_BIT]  = start_req && cfg_err;
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat_reg <= '0;
      cfg_err_reg  <= 1'b0;
      irq_o        <= 1'b0;
    end
    else
    begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      if (start_req)
        cfg_err_reg <= cfg_err;
      irq_o <= |(irq_stat_reg & irq_en_reg);
    end
  end
endmodule

// ==== test/seg_trig_record_props.sv ====
// Purpose: port-level checks for the trigger recorder
// Assumes: apb answer one cycle into the access phase
// Notes:   bound into every seg_trig_record instance
`timescale 1ns/10ps
module seg_trig_record_props
  import seg_trig_pkg::*;
#(
  parameter logic [DATA_W-1:0] PRE_MAX = PRE_EVENT_MAX
)
(
  input wire logic                mclk_i,
  input wire logic                rst_b_i,
  input wire logic                psel_i,
  input wire logic                penable_i,
  input wire logic                pwrite_i,
  input wire logic [ADDR_W-1:0]   paddr_i,
  input wire logic [DATA_W-1:0]   pwdata_i,
  input wire logic                sample_valid_i,
  input wire logic [SAMPLE_W-1:0] sample_i,
  input wire logic                pready_o,
  input wire logic [DATA_W-1:0]   prdata_o,
  input wire logic                pslverr_o,
  input wire mem_wr_type          mem_o,
  input wire logic                gate_o,
  input wire logic                irq_o
);
  default clocking dc @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  a_ready_timing: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("ready missing in second access cycle");
  a_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("ready without an access phase");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error flag outside a ready cycle");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == '0)
    else $error("read data not zero while idle");
  a_err_data: assert property (pslverr_o |-> prdata_o == '0)
    else $error("read data not zero on error");
  a_write_rdata: assert property (pready_o && $past(pwrite_i) |-> prdata_o == '0)
    else $error("read data not zero on a write answer");
  a_write_cause: assert property (mem_o.we |-> $past(sample_valid_i, 2))
    else $error("memory write without a sample two cycles before");
  a_write_data: assert property (mem_o.we |-> mem_o.data == $past(sample_i, 2))
    else $error("memory write carries the wrong sample");
endmodule

bind seg_trig_record seg_trig_record_props #(.PRE_MAX(PRE_MAX)) props_u (
  .mclk_i         (mclk_i),
  .rst_b_i        (rst_b_i),
  .psel_i         (psel_i),
  .penable_i      (penable_i),
  .pwrite_i       (pwrite_i),
  .paddr_i        (paddr_i),
  .pwdata_i       (pwdata_i),
  .sample_valid_i (sample_valid_i),
  .sample_i       (sample_i),
  .pready_o       (pready_o),
  .prdata_o       (prdata_o),
  .pslverr_o      (pslverr_o),
  .mem_o          (mem_o),
  .gate_o         (gate_o),
  .irq_o          (irq_o)
);

// ==== test/adc_stream_model.sv ====
// Purpose: converter sample stream in front of the recorder
// Assumes: bench picks the level, model paces it
// Notes:   slow mode gives a sample every other clock
`timescale 1ns/10ps
module adc_stream_model
  import seg_trig_pkg::*;
(
  input  wire logic                mclk_i,
  input  wire logic                slow_i,
  input  wire logic [SAMPLE_W-1:0] level_i,
  output logic                     valid_o,
  output logic [SAMPLE_W-1:0]      sample_o
);
  logic phase;

  initial
  begin
    phase = 1'b0;
    valid_o = 1'b0;
    sample_o = '0;
  end

  always @(posedge mclk_i)
  begin
    phase <= ~phase;
    valid_o <= ~slow_i | phase;
    // no stale value between samples
    sample_o <= (~slow_i | phase) ? level_i : ~sample_o;
  end
endmodule

// ==== test/tb.sv ====
// Purpose: self-checking bench for the level/window trigger recorder
// Assumes: segments of 4 samples, 2 after the trigger, 16 in total
// Notes:   for each mode, corner levels first, then a random level
`timescale 1ns/10ps
module tb
  import seg_trig_pkg::*;
;
  logic                clk;
  logic                rst_b;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [ADDR_W-1:0]   paddr;
  logic [DATA_W-1:0]   pwdata;
  logic                pready;
  logic [DATA_W-1:0]   prdata;
  logic                pslverr;
  logic                valid;
  logic [SAMPLE_W-1:0] smp;
  mem_wr_type          mem;
  logic                gate;
  logic                irq;
  logic                slow;
  logic [SAMPLE_W-1:0] lvl;
  logic [SAMPLE_W-1:0] cv;
  logic [DATA_W-1:0]   rv;
  logic                ev;
  int                  err_total;
  int                  n_compared;
  int                  ccnt = 0;
  int                  c0;
  logic [DATA_W-1:0]   modes [3];
  int                  safe_c [3];
  int                  cond_c [3];

  seg_trig_record #(.PRE_MAX(32'h0000_0008)) dut_u (
    .mclk_i         (clk),
    .rst_b_i        (rst_b),
    .psel_i         (psel),
    .penable_i      (penable),
    .pwrite_i       (pwrite),
    .paddr_i        (paddr),
    .pwdata_i       (pwdata),
    .sample_valid_i (valid),
    .sample_i       (smp),
    .pready_o       (pready),
    .prdata_o       (prdata),
    .pslverr_o      (pslverr),
    .mem_o          (mem),
    .gate_o         (gate),
    .irq_o          (irq)
  );

  adc_stream_model adc_u (
    .mclk_i   (clk),
    .slow_i   (slow),
    .level_i  (lvl),
    .valid_o  (valid),
    .sample_o (smp)
  );

  always #50 clk = ~clk;

  always @(posedge clk)
    if (mem.we === 1'b1 && mem.addr < 4 && mem.data === cv)
      ccnt <= ccnt + 1;

  function automatic logic cond(input int m, input int x);
    case (m)
      0: cond = x < 100;
      1: cond = x >= -100 && x <= 100;
      default: cond = x > 100 || x < -100;
    endcase
  endfunction

  function automatic int pick(input int m, input logic want);
    int x;
    do
      x = int'($urandom_range(400)) - 200;
    while (cond(m, x) != want);
    return x;
  endfunction

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] x);
    n_compared++;
    if (s !== x)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // request held until ready is seen at a rising edge; answer taken there
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1 && ++n < 50);
    if (pready !== 1'b1)
    begin
      err_total++;
      results();
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    do
      @(negedge clk);
    while (irq !== 1'b1 && ++n < 300);
    if (irq !== 1'b1)
    begin
      err_total++;
      results();
    end
  endtask

  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    slow = 1'b0;
    lvl = '0;
    cv = '0;
    err_total = 0;
    n_compared = 0;
    modes = '{BELOW_LEVEL_CONDITION, INSIDE_BAND_CONDITION, OUTSIDE_BAND_CONDITION};
    safe_c = '{100, 101, -100};
    cond_c = '{99, -100, -101};
    void'($urandom(32'hfb07));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, ADDR_SEG_LEN, '0);
    chk(rv, '0);
    apb(1'b1, ADDR_TOTAL_LEN, 32'h10);
    apb(1'b1, ADDR_POST_CNT, 32'h2);
    apb(1'b1, ADDR_LEVEL_PRI, 32'h64);
    apb(1'b1, ADDR_LEVEL_SEC, 32'hffff_ff9c);
    apb(1'b1, ADDR_SEG_LEN, 32'h10);
    apb(1'b0, ADDR_SEG_LEN, '0);
    chk(rv, 32'h10);
    apb(1'b0, 18'h00004, '0);
    chk(ev, 1'b1);
    chk(rv, '0);
    apb(1'b1, ADDR_IRQ_EN, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b0, ADDR_IRQ_STAT, '0);
    chk(rv[IRQ_ERR_BIT], 1'b1);
    chk(irq, 1'b0);
    apb(1'b1, ADDR_IRQ_EN, 32'h5);
    settle(2);
    chk(irq, 1'b1);
    apb(1'b0, ADDR_STATUS, '0);
    chk(rv[6:0], 7'h41);
    apb(1'b1, ADDR_IRQ_CLR, 32'h7);
    apb(1'b1, ADDR_IRQ_EN, 32'h1);
    apb(1'b1, ADDR_SEG_LEN, 32'h4);
    for (int m = 0; m < 3; m++)
      for (int p = 0; p < 2; p++)
      begin
        apb(1'b1, ADDR_TRIG_MODE, modes[m]);
        slow <= p[0];
        lvl <= SAMPLE_W'(p ? pick(m, 1'b1) : safe_c[m]);
        apb(1'b1, ADDR_CTRL, 32'h1);
        if (p == 0)
        begin
          settle(12);
          chk(gate, 1'b0);
          cv = SAMPLE_W'(cond_c[m]);
          c0 = ccnt;
          @(posedge clk);
          lvl <= SAMPLE_W'(cond_c[m]);
        end
        wait_irq();
        chk(gate, 1'b1);
        if (p == 0)
          chk(ccnt - c0, 2);
        apb(1'b0, ADDR_STATUS, '0);
        chk(rv[0] | rv[5], 1'b0);
        apb(1'b0, ADDR_IRQ_STAT, '0);
        chk(rv[IRQ_SEG_BIT], 1'b1);
        apb(1'b1, ADDR_IRQ_CLR, 32'h7);
        apb(1'b1, ADDR_CTRL, 32'h2);
        settle(2);
        chk(irq, 1'b0);
        apb(1'b0, ADDR_STATUS, '0);
        chk(rv[5:0], 6'h01);
      end
    results();
  end
endmodule
